// File: parallel_io_ports_test.sv
`timescale 1ns/10ps
module parallel_io_ports_test;
  import pio_pkg::*;
  logic core_clk = 0, reset = 1, pd_opt = 0, irq_opt = 0;
  pio_av_req_t av_req = '0;
  pio_av_rsp_t av_rsp;
  pio_pad_t pad1, pad2;
  logic [7:0] lv1, lv2, e1 = 0, en1 = 8'hff, e2 = 0, d, m, p, q;
  logic [3:0] irq;
  int error_cnt = 0, cmp_count = 0, seed = 96;
  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;
  pio_ports u_dut (.core_clk(core_clk), .reset(reset), .pulldown_disable_at_reset_option(pd_opt),
    .port_interrupt_option(irq_opt), .av_req(av_req), .av_rsp(av_rsp),
    .first_port_pin_in(lv1), .first_port_pad(pad1), .second_port_pin_in(lv2[3:2]),
    .second_port_pad(pad2), .port_irq_req(irq));
  pio_board u_b1 (.core_clk(core_clk), .pad(pad1), .ext_val(e1), .ext_en(en1), .level(lv1));
  pio_board u_b2 (.core_clk(core_clk), .pad(pad2), .ext_val(e2), .ext_en(8'h0c), .level(lv2));
  task automatic final_report;
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      $display("[FAIL] %s exp %h got %h", nm, e, s);
      error_cnt++;
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] idx, input logic [7:0] wd);
    @(posedge core_clk);
    av_req <= '{address: {idx, 2'b00}, read: !wr, write: wr, writedata: {24'h0, wd},
                byteenable: 4'hf};
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge core_clk);
    end while (av_rsp.waitrequest !== 1'b0);
    q = av_rsp.readdata[7:0];
    av_req <= '0;
  endtask
  task automatic rd(input string nm, input logic [4:0] idx, input logic [7:0] e);
    bus(0, idx, 8'h00);
    chk(nm, e, q);
  endtask
  // watchdog: the whole sequence needs far fewer cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    final_report;
  end
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 0;
    rd("dir1", PIO_IDX_FIRST_DIR, 8'h00);
    rd("dir2", PIO_IDX_SECOND_DIR, 8'h00);
    chk("oe1", 8'hff, pad1.oe_n);
    chk("pd1", 8'hff, pad1.pulldown_en);
    for (int k = 0; k < 8; k++) begin
      d = 8'($random(seed));
      m = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
      e1 <= 8'($random(seed));
      bus(1, PIO_IDX_FIRST_DATA, d);
      bus(1, PIO_IDX_FIRST_DIR, m);
      repeat (5) @(posedge core_clk);
      chk("oe1", ~m, pad1.oe_n);
      chk("out1", d & m, pad1.out & m);
      rd("data1", PIO_IDX_FIRST_DATA, (d & m) | (e1 & ~m));
      bus(1, PIO_IDX_FIRST_DATA, ~d);
      repeat (5) @(posedge core_clk);
      rd("data1w", PIO_IDX_FIRST_DATA, (~d & m) | (e1 & ~m));
    end
    // pulldowns with the board released
    bus(1, PIO_IDX_FIRST_DIR, 8'h00);
    en1 <= 8'h00;
    p = 8'($random(seed));
    bus(1, PIO_IDX_FIRST_PDI, p);
    repeat (5) @(posedge core_clk);
    chk("pd1", ~p, pad1.pulldown_en);
    bus(0, PIO_IDX_FIRST_DATA, 8'h00);
    chk("pulled", 8'h00, q & ~p);
    rd("pdi1", PIO_IDX_FIRST_PDI, 8'h00);
    // second port: only pin bits become outputs
    e2 <= 8'h04;
    bus(1, PIO_IDX_SECOND_DATA, 8'hff);
    bus(1, PIO_IDX_SECOND_DIR, 8'h0c);
    rd("dir2", PIO_IDX_SECOND_DIR, 8'h0c);
    repeat (5) @(posedge core_clk);
    rd("data2", PIO_IDX_SECOND_DATA, 8'h0c);
    chk("out2", 8'h0c, pad2.out & 8'h0c);
    chk("oe2", 8'h0c, ~pad2.oe_n & 8'h0c);
    bus(1, PIO_IDX_SECOND_DIR, 8'h00);
    bus(1, PIO_IDX_SECOND_PDI, 8'hff);
    repeat (5) @(posedge core_clk);
    chk("pd2", 8'h33, pad2.pulldown_en & 8'h3f);
    rd("data2in", PIO_IDX_SECOND_DATA, 8'h04);
    rd("pdi2", PIO_IDX_SECOND_PDI, 8'h00);
    rd("unmapped", 5'h1f, 8'h00);
    // interrupt option passes the low pins through
    en1 <= 8'hff;
    e1 <= 8'h0a;
    irq_opt <= 1;
    repeat (5) @(posedge core_clk);
    chk("irq", 8'h0a, {4'h0, irq});
    irq_opt <= 0;
    repeat (4) @(posedge core_clk);
    chk("irq_off", 8'h00, {4'h0, irq});
    // second reset with the pulldown option set; latch must survive
    bus(1, PIO_IDX_FIRST_DATA, 8'ha5);
    pd_opt <= 1;
    reset <= 1;
    repeat (6) @(posedge core_clk);
    reset <= 0;
    repeat (3) @(posedge core_clk);
    chk("pd1opt", 8'h00, pad1.pulldown_en);
    chk("pd2opt", 8'h00, pad2.pulldown_en & 8'h0c);
    rd("dir1opt", PIO_IDX_FIRST_DIR, 8'h00);
    bus(1, PIO_IDX_FIRST_DIR, 8'hff);
    rd("latch", PIO_IDX_FIRST_DATA, 8'ha5);
    final_report;
  end
endmodule // parallel_io_ports_test

// File: pio_board.sv
`timescale 1ns/10ps
// board side of one port: external drivers, pulldowns and floating nets
module pio_board (
  // clock
  input wire logic core_clk,
  // pad from the device
  input wire pio_pkg::pio_pad_t pad,
  // external driver
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // resolved pin level
  output logic [7:0] level
);
  import pio_pkg::*;
  logic [7:0] float_reg = 8'h00;
  // a floating net wanders every cycle, so a stale level is never trusted
  always_ff @(posedge core_clk) float_reg <= ~float_reg;
  // device driver first, then the board, then the pulldown
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level[i] = !pad.oe_n[i] ? pad.out[i] : ext_en[i] ? ext_val[i] :
                 pad.pulldown_en[i] ? 1'b0 : float_reg[i];
    end
  end
endmodule // pio_board

// File: pio_pad_ctl.sv
`timescale 1ns/10ps
// per-bit pad control for one port: driver enable and pulldown
module pio_pad_ctl (
  // clock
  input wire logic core_clk,
  // configuration
  input wire logic [7:0] latch,
  input wire logic [7:0] dir,
  input wire logic [7:0] pdi,
  input wire logic [7:0] force_pd,
  // registered pad signals
  output pio_pkg::pio_pad_t pad
);
  import pio_pkg::*;

  pio_pad_t s_reg;
  pio_pad_t s_next;

  // pulldown only on inputs; forced bits ignore the inhibit
  always_comb begin
    s_next = s_reg;
    for (int i = 0; i < 8; i++) begin
      s_next.out[i] = latch[i];
      s_next.oe_n[i] = ~dir[i];
      s_next.pulldown_en[i] = ~dir[i] & (force_pd[i] | ~pdi[i]);
    end
  end

  always_ff @(posedge core_clk) begin
    s_reg <= s_next;
  end

  assign pad = s_reg;
endmodule // pio_pad_ctl

// File: pio_pkg.sv
// Overview of operation
// - ten two-way pins: eight on the first port, two on the second, each programmable.
// - first-port output latch keeps its value through reset.
// - direction 1 drives the first-port pin, 0 leaves it high-impedance input.
// - reset clears all first-port direction bits, all pins become inputs.
// - first-port data read returns the latch where direction is 1.
// - first-port data read returns the sampled pin where direction is 0.
// - data writes always update the latch whatever the direction.
// - writing an input bit changes only the latch; reads still show the pin.
// - first-port input pulldown on while inhibit bit 0, off while 1.
// - reset clears all first-port pulldown inhibit bits.
// - with the disable-at-reset option set, reset leaves first-port and second-port pin inputs with pulldowns off.
// - with the interrupt option set, first-port bits 3..0 feed interrupt requests.
// - second-port bits 7,6 read zero; 3,2 are pins; 5,4,1,0 are internal storage.
// - reset clears every implemented second-port direction bit.
// - second-port direction 1 reads latch and drives; 0 reads pin, no drive.
// - second-port inhibit bits 3,2 turn pulldowns off when 1; reset clears them.
// - internal second-port bits keep pulldowns on whenever they are inputs.
package pio_pkg;
  // register word offsets (byte address is four times the index)
  localparam logic [4:0] PIO_IDX_FIRST_DATA = 5'h00;
  localparam logic [4:0] PIO_IDX_SECOND_DATA = 5'h01;
  localparam logic [4:0] PIO_IDX_FIRST_DIR = 5'h04;
  localparam logic [4:0] PIO_IDX_SECOND_DIR = 5'h05;
  localparam logic [4:0] PIO_IDX_FIRST_PDI = 5'h10;
  localparam logic [4:0] PIO_IDX_SECOND_PDI = 5'h11;
  // second-port implemented bits and pin bits
  localparam logic [7:0] PIO_SECOND_IMPL = 8'h3f;
  localparam logic [7:0] PIO_SECOND_PINS = 8'h0c;
  localparam logic [7:0] PIO_DIR_RESET = 8'h00;
  localparam logic [7:0] PIO_PDI_RESET = 8'h00;
  localparam logic [7:0] PIO_PDI_ALL_OFF = 8'hff;
  localparam logic [3:0] PIO_IRQ_MASK = 4'hf;
  localparam logic [31:0] PIO_UNMAPPED_DATA = 32'h0000_0000;

  // avalon request
  typedef struct packed {
    logic [6:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } pio_av_req_t;

  // avalon answer
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } pio_av_rsp_t;

  // pad signals for one eight-bit port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pulldown_en;
  } pio_pad_t;

  // bus handshake states
  typedef enum logic [1:0] {
    PIO_ST_IDLE = 2'b01,
    PIO_ST_DONE = 2'b10
  } pio_state_t;
endpackage

// File: pio_ports.sv
`timescale 1ns/10ps
// two parallel ports behind an avalon-mm slave
module pio_ports (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // option straps, sampled on the same clock
  input wire logic pulldown_disable_at_reset_option,
  input wire logic port_interrupt_option,
  // avalon-mm slave
  input wire pio_pkg::pio_av_req_t av_req,
  output pio_pkg::pio_av_rsp_t av_rsp,
  // first port pins
  input wire logic [7:0] first_port_pin_in,
  output pio_pkg::pio_pad_t first_port_pad,
  // second port pins (bits 3,2 leave the chip)
  input wire logic [1:0] second_port_pin_in,
  output pio_pkg::pio_pad_t second_port_pad,
  // interrupt requests towards the interrupt module
  output logic [3:0] port_irq_req
);
  import pio_pkg::*;

  typedef struct packed {
    pio_state_t st;
    logic [31:0] rdata;
    logic [7:0] first_latch;
    logic [7:0] second_latch;
    logic [7:0] first_dir;
    logic [7:0] second_dir;
    logic [7:0] first_pdi;
    logic [7:0] second_pdi;
    logic [3:0] irq;
    logic latch_seen;
  } pio_top_state_t;

  pio_top_state_t s_reg;
  pio_top_state_t s_next;
  logic [7:0] first_pin_sync;
  logic [7:0] second_pin_raw;
  logic [7:0] second_pin_sync;
  logic [7:0] first_rd;
  logic [7:0] second_rd;
  logic [7:0] wbyte;

  // external second-port pins sit at bits 3,2; internal bits read back as pulled low
  assign second_pin_raw = {4'h0, second_port_pin_in, 2'h0};

  pio_sync u_sync_first (
    .core_clk(core_clk),
    .async_in(first_port_pin_in),
    .sync_out(first_pin_sync)
  );

  pio_sync u_sync_second (
    .core_clk(core_clk),
    .async_in(second_pin_raw),
    .sync_out(second_pin_sync)
  );

  // read mux per bit: latch for outputs, pin for inputs
  always_comb begin
    first_rd = (s_reg.first_latch & s_reg.first_dir)
      | (first_pin_sync & ~s_reg.first_dir);
    second_rd = ((s_reg.second_latch & s_reg.second_dir)
      | (second_pin_sync & ~s_reg.second_dir)) & PIO_SECOND_IMPL;
  end

  assign wbyte = av_req.writedata[7:0];

  // one-cycle wait then answer; unmapped reads return zero, writes are dropped
  always_comb begin
    s_next = s_reg;
    s_next.irq = port_interrupt_option ? (first_pin_sync[3:0] & PIO_IRQ_MASK) : 4'h0;
    case (s_reg.st)
      PIO_ST_IDLE: begin
        if ((av_req.read || av_req.write) && !reset) begin // nothing taken while in reset
          s_next.st = PIO_ST_DONE;
          s_next.rdata = PIO_UNMAPPED_DATA;
          if (av_req.read) begin
            case (av_req.address[6:2])
              PIO_IDX_FIRST_DATA: s_next.rdata = {24'h0, first_rd};
              PIO_IDX_SECOND_DATA: s_next.rdata = {24'h0, second_rd};
              PIO_IDX_FIRST_DIR: s_next.rdata = {24'h0, s_reg.first_dir};
              PIO_IDX_SECOND_DIR: s_next.rdata = {24'h0, s_reg.second_dir};
              default: s_next.rdata = PIO_UNMAPPED_DATA;
            endcase
          end
          if (av_req.write && av_req.byteenable[0]) begin
            case (av_req.address[6:2])
              PIO_IDX_FIRST_DATA: begin
                s_next.first_latch = wbyte;
                s_next.latch_seen = 1'b1;
              end
              PIO_IDX_SECOND_DATA: s_next.second_latch = wbyte & PIO_SECOND_IMPL;
              PIO_IDX_FIRST_DIR: s_next.first_dir = wbyte;
              PIO_IDX_SECOND_DIR: s_next.second_dir = wbyte & PIO_SECOND_IMPL;
              PIO_IDX_FIRST_PDI: s_next.first_pdi = wbyte;
              PIO_IDX_SECOND_PDI: s_next.second_pdi = wbyte & PIO_SECOND_PINS;
              default: s_next.st = PIO_ST_DONE;
            endcase
          end
        end
      end
      PIO_ST_DONE: begin
        s_next.st = PIO_ST_IDLE;
      end
      default: begin
        s_next.st = PIO_ST_IDLE;
      end
    endcase
  end

  // latches carry no reset so their contents survive it
  always_ff @(posedge core_clk) begin
    s_reg.first_latch <= s_next.first_latch;
    s_reg.second_latch <= s_next.second_latch;
    s_reg.irq <= s_next.irq;
    // checker helper: unknown until the first data write, kept through reset like the latch
    s_reg.latch_seen <= s_next.latch_seen;
    if (reset) begin
      s_reg.st <= PIO_ST_IDLE;
      s_reg.rdata <= PIO_UNMAPPED_DATA;
      s_reg.first_dir <= PIO_DIR_RESET;
      s_reg.second_dir <= PIO_DIR_RESET;
      // option strap is synchronous with core_clk, so sampling it in reset is safe
      s_reg.first_pdi <= pulldown_disable_at_reset_option ? PIO_PDI_ALL_OFF
        : PIO_PDI_RESET;
      s_reg.second_pdi <= pulldown_disable_at_reset_option ? PIO_SECOND_PINS
        : PIO_PDI_RESET;
    end else begin
      s_reg.st <= s_next.st;
      s_reg.rdata <= s_next.rdata;
      s_reg.first_dir <= s_next.first_dir;
      s_reg.second_dir <= s_next.second_dir;
      s_reg.first_pdi <= s_next.first_pdi;
      s_reg.second_pdi <= s_next.second_pdi;
    end
  end

  // pad drivers for both ports; internal second-port bits keep pulldowns forced while they are inputs
  pio_pad_ctl u_pad_first (
    .core_clk(core_clk),
    .latch(s_reg.first_latch),
    .dir(s_reg.first_dir),
    .pdi(s_reg.first_pdi),
    .force_pd(8'h00),
    .pad(first_port_pad)
  );

  pio_pad_ctl u_pad_second (
    .core_clk(core_clk),
    .latch(s_reg.second_latch),
    .dir(s_reg.second_dir),
    .pdi(s_reg.second_pdi),
    .force_pd(~PIO_SECOND_PINS),
    .pad(second_port_pad)
  );

  // answer registered; waitrequest is low only in the done state
  assign av_rsp.readdata = s_reg.rdata;
  assign av_rsp.waitrequest = (s_reg.st != PIO_ST_DONE);
  assign port_irq_req = s_reg.irq;

  // assertions
  property p_dir_reset;
    @(posedge core_clk) reset
      |=> (s_reg.first_dir == PIO_DIR_RESET && s_reg.second_dir == PIO_DIR_RESET);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared");

  // the latch powers up unknown, so the check starts once software has written it
  property p_latch_keep;
    @(posedge core_clk) (reset && s_reg.latch_seen)
      |=> (s_reg.first_latch == $past(s_reg.first_latch));
  endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("latch changed in reset");

  property p_write_latch;
    @(posedge core_clk) disable iff (reset)
      (s_reg.st == PIO_ST_IDLE && av_req.write && av_req.byteenable[0]
       && av_req.address[6:2] == PIO_IDX_FIRST_DATA) |=> s_reg.first_latch == $past(wbyte);
  endproperty
  a_write_latch: assert property (p_write_latch) else $error("latch not written");

  property p_read_mux;
    @(posedge core_clk) disable iff (reset)
      (s_reg.st == PIO_ST_IDLE && av_req.read && av_req.address[6:2] == PIO_IDX_FIRST_DATA)
      |=> av_rsp.readdata[7:0] == $past(first_rd) && !av_rsp.waitrequest;
  endproperty
  a_read_mux: assert property (p_read_mux) else $error("port read wrong");

  property p_pdi_read;
    @(posedge core_clk) disable iff (reset)
      (s_reg.st == PIO_ST_IDLE && av_req.read && (av_req.address[6:2] == PIO_IDX_FIRST_PDI
       || av_req.address[6:2] == PIO_IDX_SECOND_PDI))
      |=> av_rsp.readdata == 32'h0;
  endproperty
  a_pdi_read: assert property (p_pdi_read) else $error("inhibit read not zero");

  property p_oe;
    @(posedge core_clk) disable iff (reset)
      ##1 first_port_pad.oe_n == ~$past(s_reg.first_dir);
  endproperty
  a_oe: assert property (p_oe) else $error("driver enable wrong");

  property p_second_top;
    @(posedge core_clk) disable iff (reset)
      (s_reg.st == PIO_ST_IDLE && av_req.read
       && (av_req.address[6:2] == PIO_IDX_SECOND_DATA
       || av_req.address[6:2] == PIO_IDX_SECOND_DIR))
      |=> av_rsp.readdata[7:6] == 2'b00 && s_reg.second_dir[7:6] == 2'b00;
  endproperty
  a_second_top: assert property (p_second_top) else $error("second port top bits set");

  property p_internal_pd;
    @(posedge core_clk) disable iff (reset)
      ##1 ($past(~s_reg.second_dir) & 8'h33) == (second_port_pad.pulldown_en & 8'h33);
  endproperty
  a_internal_pd: assert property (p_internal_pd) else $error("internal pulldown off");

  property p_irq;
    @(posedge core_clk) disable iff (reset)
      !port_interrupt_option |=> port_irq_req == 4'h0;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without option");

  // a request taken in the idle state
  sequence s_taken;
    s_reg.st == PIO_ST_IDLE && (av_req.read || av_req.write);
  endsequence

  // waitrequest low for exactly one cycle, then high again
  sequence s_one_cycle_answer;
    ##1 !av_rsp.waitrequest ##1 av_rsp.waitrequest;
  endsequence

  // every taken request gets one answer cycle, never a stretched one
  property p_handshake;
    @(posedge core_clk) disable iff (reset)
      s_taken |-> s_one_cycle_answer;
  endproperty
  a_handshake: assert property (p_handshake) else $error("answer not one cycle wide");

  // read data stands until the next taken request
  property p_rdata_hold;
    @(posedge core_clk) disable iff (reset)
      not s_taken |=> $stable(av_rsp.readdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  // first-port inhibits after reset follow the option strap
  property p_pdi_reset1;
    @(posedge core_clk) reset |=> s_reg.first_pdi
      == ($past(pulldown_disable_at_reset_option) ? PIO_PDI_ALL_OFF : PIO_PDI_RESET);
  endproperty
  a_pdi_reset1: assert property (p_pdi_reset1) else $error("first inhibit reset wrong");

  // second-port inhibits after reset follow the option strap
  property p_pdi_reset2;
    @(posedge core_clk) reset |=> s_reg.second_pdi
      == ($past(pulldown_disable_at_reset_option) ? PIO_SECOND_PINS : PIO_PDI_RESET);
  endproperty
  a_pdi_reset2: assert property (p_pdi_reset2) else $error("second inhibit reset wrong");

  // direction register reads back what was stored
  property p_read_dir;
    @(posedge core_clk) disable iff (reset)
      (s_reg.st == PIO_ST_IDLE && av_req.read && av_req.address[6:2] == PIO_IDX_FIRST_DIR)
      |=> av_rsp.readdata == {24'h0, $past(s_reg.first_dir)};
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("direction read wrong");

  // second-port data read uses the per-bit latch or pin choice
  property p_read_second;
    @(posedge core_clk) disable iff (reset)
      (s_reg.st == PIO_ST_IDLE && av_req.read && av_req.address[6:2] == PIO_IDX_SECOND_DATA)
      |=> av_rsp.readdata[7:0] == $past(second_rd);
  endproperty
  a_read_second: assert property (p_read_second) else $error("second port read wrong");

  // first-port direction write lands at the taking edge
  property p_write_dir1;
    @(posedge core_clk) disable iff (reset)
      (s_reg.st == PIO_ST_IDLE && av_req.write && av_req.byteenable[0]
       && av_req.address[6:2] == PIO_IDX_FIRST_DIR) |=> s_reg.first_dir == $past(wbyte);
  endproperty
  a_write_dir1: assert property (p_write_dir1) else $error("first direction not written");

  // second-port direction keeps only implemented bits
  property p_write_dir2;
    @(posedge core_clk) disable iff (reset)
      (s_reg.st == PIO_ST_IDLE && av_req.write && av_req.byteenable[0]
       && av_req.address[6:2] == PIO_IDX_SECOND_DIR)
      |=> s_reg.second_dir == ($past(wbyte) & PIO_SECOND_IMPL);
  endproperty
  a_write_dir2: assert property (p_write_dir2) else $error("second direction not written");

  // second-port latch keeps only implemented bits, whatever the direction
  property p_write_latch2;
    @(posedge core_clk) disable iff (reset)
      (s_reg.st == PIO_ST_IDLE && av_req.write && av_req.byteenable[0]
       && av_req.address[6:2] == PIO_IDX_SECOND_DATA)
      |=> s_reg.second_latch == ($past(wbyte) & PIO_SECOND_IMPL);
  endproperty
  a_write_latch2: assert property (p_write_latch2) else $error("second latch not written");

  // first-port inhibit write lands as written
  property p_write_pdi1;
    @(posedge core_clk) disable iff (reset)
      (s_reg.st == PIO_ST_IDLE && av_req.write && av_req.byteenable[0]
       && av_req.address[6:2] == PIO_IDX_FIRST_PDI) |=> s_reg.first_pdi == $past(wbyte);
  endproperty
  a_write_pdi1: assert property (p_write_pdi1) else $error("first inhibit not written");

  // second-port inhibit keeps only the two pin bits
  property p_write_pdi2;
    @(posedge core_clk) disable iff (reset)
      (s_reg.st == PIO_ST_IDLE && av_req.write && av_req.byteenable[0]
       && av_req.address[6:2] == PIO_IDX_SECOND_PDI)
      |=> s_reg.second_pdi == ($past(wbyte) & PIO_SECOND_PINS);
  endproperty
  a_write_pdi2: assert property (p_write_pdi2) else $error("second inhibit not written");

  // first-port pulldown only on inputs whose inhibit is clear
  property p_pd1;
    @(posedge core_clk) disable iff (reset)
      ##1 first_port_pad.pulldown_en == $past(~s_reg.first_dir & ~s_reg.first_pdi);
  endproperty
  a_pd1: assert property (p_pd1) else $error("first pulldown wrong");

  // second-port pin pulldowns follow direction and inhibit
  property p_pd2;
    @(posedge core_clk) disable iff (reset)
      ##1 (second_port_pad.pulldown_en & PIO_SECOND_PINS)
      == ($past(~s_reg.second_dir & ~s_reg.second_pdi) & PIO_SECOND_PINS);
  endproperty
  a_pd2: assert property (p_pd2) else $error("second pulldown wrong");

  // second-port drivers follow the direction bits
  property p_oe2;
    @(posedge core_clk) disable iff (reset)
      ##1 second_port_pad.oe_n == ~$past(s_reg.second_dir);
  endproperty
  a_oe2: assert property (p_oe2) else $error("second driver enable wrong");

  // with the option set the low synced pins reach the requests
  property p_irq_on;
    @(posedge core_clk) disable iff (reset)
      port_interrupt_option |=> port_irq_req == $past(first_pin_sync[3:0]);
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq does not follow pins");
endmodule // pio_ports

// File: pio_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser for pin levels
module pio_sync (
  // clock
  input wire logic core_clk,
  // pin levels
  input wire logic [7:0] async_in,
  // synchronised levels
  output logic [7:0] sync_out
);
  import pio_pkg::*;

  typedef struct packed {
    logic [7:0] stage1;
    logic [7:0] stage2;
  } pio_sync_state_t;

  pio_sync_state_t s_reg;
  pio_sync_state_t s_next;

  // first stage feeds only the second; no reset so pin noise never meets reset logic
  always_comb begin
    s_next = s_reg;
    s_next.stage1 = async_in;
    s_next.stage2 = s_reg.stage1;
  end

  always_ff @(posedge core_clk) begin
    s_reg <= s_next;
  end

  assign sync_out = s_reg.stage2;
endmodule // pio_sync
